// >>> logic/edmi_core.sv
/*
  external data memory interface: routes core external-move accesses to
  on-chip data ram or to off-chip memory on one of two port groups.
  assumes the ram answers within the cycle of its enable, pins are parked by
  port latches when released, and pin inputs are asynchronous.
*/
// What this block does
// - group select picks lower or upper ports
// - mux select shares or splits address/data
// - mode 00: on-chip only, 8k wrap
// - internal 8-bit address: page high, index low
// - split modes: below 8k on-chip, above off-chip
// - split no bank: page decides, high undriven
// - split bank: page and index drive all
// - pointer decides; off-chip drives all sixteen
// - mode 11: everything off-chip, ram hidden
// - external 8-bit: ignore page, high undriven
// - latch strobe high/low 1 to 4 cycles
// - latch width only matters when multiplexed
// - first phase: strobe high, low address
// - second phase: data on shared pins
// - all timing in whole clock periods
// - access is timing plus 4 cycles
// - multiplexed adds at least 2 cycles
// - setup and hold reset to maximum
// - top two config bits read zero
// - pins claimed only during off-chip access
// - input pins have drivers disabled
// - hold field gives 0 to 3 cycles
module edmi_core
  import edmi_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            sfr_addr,
  input  wire logic                  sfr_wr,
  input  wire logic [7:0]            sfr_wdata,
  output logic      [7:0]            sfr_rdata,
  input  wire logic                  req,
  input  wire logic                  req_write,
  input  wire logic                  req_wide,
  input  wire logic [15:0]           data_pointer,
  input  wire logic [7:0]            indirect_index_register,
  input  wire logic [7:0]            req_wdata,
  output logic                       busy,
  output logic                       done,
  output logic      [7:0]            rdata,
  output logic                       ram_en,
  output logic                       ram_we,
  output logic      [RAM_ADDR_W-1:0] ram_addr,
  output logic      [7:0]            ram_wdata,
  input  wire logic [7:0]            ram_rdata,
  output logic      [1:0][7:0]       addr_hi_o,
  output logic      [1:0]            addr_hi_oe_n,
  output logic      [1:0][7:0]       addr_lo_o,
  output logic      [1:0]            addr_lo_oe_n,
  output logic      [1:0][7:0]       data_o,
  output logic      [1:0]            data_oe_n,
  input  wire logic [1:0][7:0]       data_i,
  output logic      [1:0]            ale_o,
  output logic      [1:0]            rd_n_o,
  output logic      [1:0]            wr_n_o,
  output logic      [1:0]            ctl_oe_n
);

  typedef struct packed {
    logic [5:0]            cfg;
    logic [7:0]            page;
    logic [7:0]            tmg;
    edmi_state_e           st;
    logic [3:0]            cnt;
    logic                  grp;
    logic                  mux;
    logic                  wr;
    logic [7:0]            wdat;
    logic [7:0]            alo;
    logic [1:0][7:0]       sync1;
    logic [1:0][7:0]       sync2;
    logic [7:0]            sfr_rdata;
    logic                  busy;
    logic                  done;
    logic [7:0]            rdata;
    logic                  ram_en;
    logic                  ram_we;
    logic [RAM_ADDR_W-1:0] ram_addr;
    logic [7:0]            ram_wdata;
    logic [1:0][7:0]       ahi;
    logic [1:0]            ahi_oe_n;
    logic [1:0][7:0]       alo_p;
    logic [1:0]            alo_oe_n;
    logic [1:0][7:0]       dat;
    logic [1:0]            dat_oe_n;
    logic [1:0]            ale;
    logic [1:0]            rd_n;
    logic [1:0]            wr_n;
    logic [1:0]            ctl_oe_n;
  } edmi_state_s;

  edmi_state_s q;
  edmi_state_s next_q;

  always_comb begin
    logic [15:0] eff;
    logic [1:0]  mode;
    logic        off;
    logic        drv_hi;
    logic        g;
    logic        mux;
    eff    = 16'h0000;
    mode   = q.cfg[CFG_MODE_HI:CFG_MODE_LO];
    off    = 1'b0;
    drv_hi = 1'b0;
    g      = q.cfg[CFG_GRP_BIT];
    mux    = ~q.cfg[CFG_NMUX_BIT];
    next_q = q;
    next_q.done   = 1'b0;
    next_q.ram_en = 1'b0;
    // first stage feeds only the second stage
    next_q.sync1 = data_i;
    next_q.sync2 = q.sync1;

    if (sfr_wr) begin
      case (sfr_addr)
        EXT_MEM_CONFIG_ADDR: next_q.cfg = sfr_wdata[5:0];
        PAGE_HIGH_BYTE_ADDR: next_q.page = sfr_wdata;
        TIMING_CONTROL_ADDR: next_q.tmg = sfr_wdata;
        default: ;
      endcase
    end
    case (sfr_addr)
      EXT_MEM_CONFIG_ADDR: next_q.sfr_rdata = {2'h0, q.cfg};
      PAGE_HIGH_BYTE_ADDR: next_q.sfr_rdata = q.page;
      TIMING_CONTROL_ADDR: next_q.sfr_rdata = q.tmg;
      default:             next_q.sfr_rdata = 8'h00;
    endcase

    case (q.st)
      ST_IDLE: begin
        if (req) begin
          eff = req_wide ? data_pointer : {q.page, indirect_index_register};
          case (mode)
            MODE_INTERNAL: off = 1'b0;
            MODE_EXTERNAL: off = 1'b1;
            default:       off = (eff[15:13] != ONCHIP_TOP_Z);
          endcase
          drv_hi = req_wide | (mode == MODE_BANK);
          next_q.busy = 1'b1;
          if (!off) begin
            next_q.ram_en    = 1'b1;
            next_q.ram_we    = req_write;
            next_q.ram_addr  = eff[RAM_ADDR_W-1:0];
            next_q.ram_wdata = req_wdata;
            next_q.st        = ST_RAM;
          end else begin
            // latched so a config write mid-access cannot move the pins
            next_q.grp  = g;
            next_q.mux  = mux;
            next_q.wr   = req_write;
            next_q.wdat = req_wdata;
            next_q.alo  = eff[7:0];
            next_q.st   = ST_START;
            next_q.ctl_oe_n[g] = 1'b0;
            next_q.rd_n[g]     = 1'b1;
            next_q.wr_n[g]     = 1'b1;
            next_q.ale[g]      = 1'b0;
            if (drv_hi) begin
              next_q.ahi[g]      = eff[15:8];
              next_q.ahi_oe_n[g] = 1'b0;
            end
            if (mux) begin
              next_q.dat[g]      = eff[7:0];
              next_q.dat_oe_n[g] = 1'b0;
            end else begin
              next_q.alo_p[g]    = eff[7:0];
              next_q.alo_oe_n[g] = 1'b0;
              next_q.dat[g]      = req_wdata;
              next_q.dat_oe_n[g] = ~req_write;
            end
          end
        end
      end
      ST_RAM: begin
        if (!q.ram_we) begin
          next_q.rdata = ram_rdata;
        end
        next_q.done = 1'b1;
        next_q.busy = 1'b0;
        next_q.st   = ST_IDLE;
      end
      ST_START: begin
        if (q.mux) begin
          next_q.ale[q.grp] = 1'b1;
          next_q.cnt = {2'h0, q.cfg[CFG_ALE_HI:CFG_ALE_LO]};
          next_q.st  = ST_ALE_H;
        end else if (q.tmg[TMG_SETUP_HI:TMG_SETUP_LO] != 2'h0) begin
          // latch width ignored when not multiplexed
          next_q.cnt = {2'h0, q.tmg[TMG_SETUP_HI:TMG_SETUP_LO]} - 4'h1;
          next_q.st  = ST_SETUP;
        end else begin
          next_q.cnt = q.tmg[TMG_STRB_HI:TMG_STRB_LO];
          next_q.st  = ST_STROBE;
          next_q.rd_n[q.grp] = q.wr;
          next_q.wr_n[q.grp] = ~q.wr;
        end
      end
      ST_ALE_H: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0) begin
          next_q.ale[q.grp] = 1'b0;
          next_q.cnt = {2'h0, q.cfg[CFG_ALE_HI:CFG_ALE_LO]};
          next_q.st  = ST_ALE_L;
        end
      end
      ST_ALE_L: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0) begin
          // address stays on the shared pins through the low time
          next_q.dat[q.grp]      = q.wdat;
          next_q.dat_oe_n[q.grp] = ~q.wr;
          if (q.tmg[TMG_SETUP_HI:TMG_SETUP_LO] != 2'h0) begin
            next_q.cnt = {2'h0, q.tmg[TMG_SETUP_HI:TMG_SETUP_LO]} - 4'h1;
            next_q.st  = ST_SETUP;
          end else begin
            next_q.cnt = q.tmg[TMG_STRB_HI:TMG_STRB_LO];
            next_q.st  = ST_STROBE;
            next_q.rd_n[q.grp] = q.wr;
            next_q.wr_n[q.grp] = ~q.wr;
          end
        end
      end
      ST_SETUP: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0) begin
          next_q.cnt = q.tmg[TMG_STRB_HI:TMG_STRB_LO];
          next_q.st  = ST_STROBE;
          next_q.rd_n[q.grp] = q.wr;
          next_q.wr_n[q.grp] = ~q.wr;
        end
      end
      ST_STROBE: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0) begin
          // synchroniser lags two cycles: read strobes under three cycles capture stale data
          if (!q.wr) begin
            next_q.rdata = q.sync2[q.grp];
          end
          next_q.rd_n[q.grp] = 1'b1;
          next_q.wr_n[q.grp] = 1'b1;
          if (q.tmg[TMG_HOLD_HI:TMG_HOLD_LO] != 2'h0) begin
            next_q.cnt = {2'h0, q.tmg[TMG_HOLD_HI:TMG_HOLD_LO]} - 4'h1;
            next_q.st  = ST_HOLD;
          end else begin
            next_q.cnt = END_CYCLES_M1;
            next_q.st  = ST_END;
          end
        end
      end
      ST_HOLD: begin
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0) begin
          next_q.cnt = END_CYCLES_M1;
          next_q.st  = ST_END;
        end
      end
      ST_END: begin
        // hand pins back to the port latches
        next_q.ahi_oe_n = 2'h3;
        next_q.alo_oe_n = 2'h3;
        next_q.dat_oe_n = 2'h3;
        next_q.ctl_oe_n = 2'h3;
        next_q.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h0) begin
          next_q.done = 1'b1;
          next_q.busy = 1'b0;
          next_q.st   = ST_IDLE;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q          <= '0;
      q.cfg      <= CFG_RESET;
      q.page     <= PAGE_RESET;
      q.tmg      <= TMG_RESET;
      q.st       <= ST_IDLE;
      q.ahi_oe_n <= 2'h3;
      q.alo_oe_n <= 2'h3;
      q.dat_oe_n <= 2'h3;
      q.ctl_oe_n <= 2'h3;
      q.rd_n     <= 2'h3;
      q.wr_n     <= 2'h3;
    end else begin
      q <= next_q;
    end
  end

  assign sfr_rdata    = q.sfr_rdata;
  assign busy         = q.busy;
  assign done         = q.done;
  assign rdata        = q.rdata;
  assign ram_en       = q.ram_en;
  assign ram_we       = q.ram_we;
  assign ram_addr     = q.ram_addr;
  assign ram_wdata    = q.ram_wdata;
  assign addr_hi_o    = q.ahi;
  assign addr_hi_oe_n = q.ahi_oe_n;
  assign addr_lo_o    = q.alo_p;
  assign addr_lo_oe_n = q.alo_oe_n;
  assign data_o       = q.dat;
  assign data_oe_n    = q.dat_oe_n;
  assign ale_o        = q.ale;
  assign rd_n_o       = q.rd_n;
  assign wr_n_o       = q.wr_n;
  assign ctl_oe_n     = q.ctl_oe_n;

endmodule

// >>> logic/edmi_pkg.sv
/*
  constants and types shared by the external data memory interface.
  assumes one system clock and a synchronous active-high reset.
*/
package edmi_pkg;
  // special function register addresses
  localparam logic [7:0] EXT_MEM_CONFIG_ADDR = 8'hA3;
  localparam logic [7:0] PAGE_HIGH_BYTE_ADDR = 8'hA2;
  localparam logic [7:0] TIMING_CONTROL_ADDR = 8'hA1;

  // reset values
  localparam logic [5:0] CFG_RESET  = 6'h03;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] TMG_RESET  = 8'hFF;

  // ext_mem_config field positions
  localparam int CFG_GRP_BIT  = 5;
  localparam int CFG_NMUX_BIT = 4;
  localparam int CFG_MODE_HI  = 3;
  localparam int CFG_MODE_LO  = 2;
  localparam int CFG_ALE_HI   = 1;
  localparam int CFG_ALE_LO   = 0;

  // timing_control_register field positions
  localparam int TMG_SETUP_HI = 7;
  localparam int TMG_SETUP_LO = 6;
  localparam int TMG_STRB_HI  = 5;
  localparam int TMG_STRB_LO  = 2;
  localparam int TMG_HOLD_HI  = 1;
  localparam int TMG_HOLD_LO  = 0;

  // memory_map_mode encodings
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT    = 2'h1;
  localparam logic [1:0] MODE_BANK     = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  // on-chip data ram spans the 8 k below this boundary
  localparam int         RAM_ADDR_W   = 13;
  localparam logic [2:0] ONCHIP_TOP_Z = 3'h0;

  // fixed overhead: one start cycle plus one more closing cycle than this
  localparam logic [3:0] END_CYCLES_M1 = 4'h2;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RAM,
    ST_START,
    ST_ALE_H,
    ST_ALE_L,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_END
  } edmi_state_e;
endpackage

// >>> bench/edmi_monitor.sv
/* pin-level assertions for the external data memory interface.
   assumes one clock and a synchronous active-high reset. */
module edmi_monitor (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       busy,
  input wire logic       done,
  input wire logic       ram_en,
  input wire logic [1:0] ale_o,
  input wire logic [1:0] rd_n_o,
  input wire logic [1:0] wr_n_o,
  input wire logic [1:0] ctl_oe_n,
  input wire logic [1:0] data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_one_strb; (~rd_n_o & ~wr_n_o) == 2'h0; endproperty
  a_one_strb: assert property (p_one_strb) else $error("both strobes low");
  property p_owned; ((~rd_n_o | ~wr_n_o | ale_o) & ctl_oe_n) == 2'h0; endproperty
  a_owned: assert property (p_owned) else $error("strobe on released pin");
  property p_claim; ctl_oe_n != 2'h3 |-> busy; endproperty
  a_claim: assert property (p_claim) else $error("pins held while idle");
  property p_rd_hiz; (~rd_n_o & ~data_oe_n) == 2'h0; endproperty
  a_rd_hiz: assert property (p_rd_hiz) else $error("data driven in read");
  property p_wr_data; (~wr_n_o & data_oe_n) == 2'h0; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data missing");
  property p_ale_sep; (ale_o & ~(rd_n_o & wr_n_o)) == 2'h0; endproperty
  a_ale_sep: assert property (p_ale_sep) else $error("latch overlaps strobe");
  property p_ram; ram_en |-> ctl_oe_n == 2'h3 ##1 done; endproperty
  a_ram: assert property (p_ram) else $error("on-chip access slow");
  property p_min; $fell(&ctl_oe_n) |-> !done [*5] ##[1:40] done; endproperty
  a_min: assert property (p_min) else $error("off-chip length");
  property p_min_mux; $rose(ale_o != 2'h0) |-> !done [*6]; endproperty
  a_min_mux: assert property (p_min_mux) else $error("muxed too short");
endmodule
bind edmi_core edmi_monitor u_mon (.clk, .rst, .busy, .done, .ram_en, .ale_o, .rd_n_o,
  .wr_n_o, .ctl_oe_n, .data_oe_n);

// >>> bench/edmi_mem_model.sv
/* external asynchronous memory with its address latch.
   assumes released address pins are parked high by port latches. */
module edmi_mem_model (
  input  wire logic            clk,
  input  wire logic            mux,
  input  wire logic [1:0][7:0] addr_hi_o,
  input  wire logic [1:0]      addr_hi_oe_n,
  input  wire logic [1:0][7:0] addr_lo_o,
  input  wire logic [1:0]      addr_lo_oe_n,
  input  wire logic [1:0][7:0] data_o,
  input  wire logic [1:0]      ale_o,
  input  wire logic [1:0]      rd_n_o,
  input  wire logic [1:0]      wr_n_o,
  input  wire logic [1:0]      ctl_oe_n,
  output logic      [1:0][7:0] data_i,
  output logic      [15:0]     last_addr,
  output logic                 last_grp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat;
  logic        tgl = 1'b0;
  logic        g;
  logic [15:0] a;
  assign g = ctl_oe_n[0];
  // transparent while high, frozen once low
  always_latch if (ale_o[g]) lat <= data_o[g];
  assign a = {addr_hi_oe_n[g] ? 8'hFF : addr_hi_o[g],
              mux ? lat : (addr_lo_oe_n[g] ? 8'hFF : addr_lo_o[g])};
  // released lines toggle so stale data never passes
  assign data_i = !rd_n_o[g] ? {2{mem[a]}} : {16{tgl}};
  always @(posedge clk) begin
    tgl <= ~tgl;
    if (!wr_n_o[g]) mem[a] <= data_o[g];
    if (!(rd_n_o[g] & wr_n_o[g])) begin
      last_addr <= a;
      last_grp <= g;
    end
  end
endmodule

// >>> bench/testbench.sv
/* register and access sequences for the external data memory interface.
   assumes the pin-side memory model and a local on-chip ram model. */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %0t %h %h", $time, g, e); end end
module testbench import edmi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, req = 1'b0, req_write = 1'b0;
  logic req_wide = 1'b0, mux = 1'b0, busy, done, ram_en, ram_we, last_grp;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, req_wdata = 8'h00, ram_rdata;
  logic [7:0] indirect_index_register = 8'h00, sfr_rdata, rdata, ram_wdata;
  logic [15:0] data_pointer = 16'h0000, last_addr;
  logic [RAM_ADDR_W-1:0] ram_addr, ram_last;
  logic [1:0][7:0] addr_hi_o, addr_lo_o, data_o, data_i;
  logic [1:0] addr_hi_oe_n, addr_lo_oe_n, data_oe_n, ale_o, rd_n_o, wr_n_o, ctl_oe_n;
  logic [7:0] ram [0:8191];
  int err_total = 0, check_count = 0;
  always #20 clk = ~clk;
  edmi_core dut (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .req, .req_write,
    .req_wide, .data_pointer, .indirect_index_register, .req_wdata, .busy, .done, .rdata,
    .ram_en, .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .addr_hi_o, .addr_hi_oe_n,
    .addr_lo_o, .addr_lo_oe_n, .data_o, .data_oe_n, .data_i, .ale_o, .rd_n_o, .wr_n_o,
    .ctl_oe_n);
  edmi_mem_model u_mem (.clk, .mux, .addr_hi_o, .addr_hi_oe_n, .addr_lo_o, .addr_lo_oe_n,
    .data_o, .ale_o,
    .rd_n_o, .wr_n_o, .ctl_oe_n, .data_i, .last_addr, .last_grp);
  // read data stands in the enable cycle; the core takes it at that cycle's end
  assign ram_rdata = ram[ram_addr];
  always @(posedge clk) if (ram_en) begin
    if (ram_we) ram[ram_addr] <= ram_wdata;
    ram_last <= ram_addr;
  end
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    repeat (2) @(posedge clk);
    #1 `CHK(sfr_rdata, e)
  endtask
  // 8-bit accesses take the page from p[15:8] and the index from p[7:0]
  task automatic acc(input logic w, input logic wd, input logic [15:0] p,
                     input logic [7:0] d, input int n);
    int k;
    if (!wd) wreg(PAGE_HIGH_BYTE_ADDR, p[15:8]);
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_wide <= wd;
    data_pointer <= p;
    indirect_index_register <= p[7:0];
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      #1;
    end while (done !== 1'b1 && k < 60);
    `CHK(k, n)
    if (!w) `CHK(rdata, d)
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(EXT_MEM_CONFIG_ADDR, 8'h03);
    rreg(TIMING_CONTROL_ADDR, 8'hFF);
    rreg(PAGE_HIGH_BYTE_ADDR, 8'h00);
    rreg(8'h55, 8'h00);
    wreg(EXT_MEM_CONFIG_ADDR, 8'hFF);
    rreg(EXT_MEM_CONFIG_ADDR, 8'h3F);
    wreg(EXT_MEM_CONFIG_ADDR, 8'h00);
    acc(1, 1, 16'h4005, 8'h5A, 1);
    `CHK(ram_last, 13'h0005)
    acc(0, 1, 16'h0005, 8'h5A, 1);
    acc(1, 0, 16'h1234, 8'hC3, 1);
    `CHK(ram_last, 13'h1234)
    // latch width set to its widest, must not stretch a non-muxed access
    wreg(EXT_MEM_CONFIG_ADDR, 8'h1F);
    wreg(TIMING_CONTROL_ADDR, 8'h00);
    acc(1, 1, 16'h0012, 8'hA5, 5);
    `CHK(last_addr, 16'h0012)
    `CHK(last_grp, 1'b0)
    wreg(TIMING_CONTROL_ADDR, 8'h08);
    acc(0, 1, 16'h0012, 8'hA5, 7);
    acc(1, 0, 16'h7744, 8'h3C, 7);
    `CHK(last_addr, 16'hFF44)
    wreg(TIMING_CONTROL_ADDR, 8'hC3);
    acc(1, 1, 16'hABCD, 8'h11, 11);
    wreg(EXT_MEM_CONFIG_ADDR, 8'h14);
    wreg(TIMING_CONTROL_ADDR, 8'h08);
    acc(1, 0, 16'h1FFF, 8'h21, 1);
    acc(1, 0, 16'h8010, 8'h22, 7);
    `CHK(last_addr, 16'hFF10)
    acc(1, 1, 16'h2000, 8'h23, 7);
    `CHK(last_addr, 16'h2000)
    acc(0, 1, 16'h1FFF, 8'h21, 1);
    wreg(EXT_MEM_CONFIG_ADDR, 8'h18);
    acc(1, 0, 16'h8010, 8'h24, 7);
    `CHK(last_addr, 16'h8010)
    acc(0, 1, 16'h8010, 8'h24, 7);
    mux <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      wreg(EXT_MEM_CONFIG_ADDR, 8'h2C | 8'(a));
      acc(1, 1, 16'h3300 | 16'(a), 8'h90 | 8'(a), 9 + 2 * a);
      `CHK(last_addr, 16'h3300 | 16'(a))
      `CHK(last_grp, 1'b1)
      acc(0, 1, 16'h3300 | 16'(a), 8'h90 | 8'(a), 9 + 2 * a);
    end
    test_done;
  end
  // far beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    err_total++;
    test_done;
  end
endmodule
